// >>> hdl/iwd_map.vh
// offsets, command codes and timing constants of the i/o port watchdog
`ifndef IWD_MAP_VH
`define IWD_MAP_VH
`define IWD_PORT_ADDR 16'h0443
`define IWD_ADDR_W 16
`define IWD_DATA_W 8
`define IWD_CMD_REFRESH 8'h01
`define IWD_CMD_DISABLE 8'h00
`define IWD_CLK_HZ 100000000
`define IWD_TIMEOUT_MS 1600
// 1.6 s at the 100 MHz board clock, sized to the counter width
`define IWD_TIMEOUT_CYC 28'h9896800
`define IWD_CNT_W 28
`define IWD_RST_PULSE_CYC 8'h10
`define IWD_STAT_ARMED_BIT 0
`define IWD_STAT_EXPIRED_BIT 1
`define IWD_STAT_ACTION_BIT 2
`endif

// >>> hdl/iwd_sync.v
// two-flop synchroniser for one pin-level input
`timescale 1ns/1ps
`default_nettype none
module iwd_sync (
  input wire clk,
  input wire resetn,
  input wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;

  // first flop feeds only the second one
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

// >>> hdl/iwd_top.v
// i/o port watchdog timer: port decode, countdown and expiry action
//
// Overview of operation
// - port 443 hex decoded; write of 1 refreshes and enables the timer
// - first read of the port arms the watchdog
// - armed timer expires after 1.6 s without a refresh write
// - expiry gives one action: processor reset pulse or interrupt request
// - write of 0 to the port disarms the watchdog
// - board strap selects reset or interrupt as the expiry action
`timescale 1ns/1ps
`default_nettype none
`include "iwd_map.vh"
module iwd_top #(
  parameter [`IWD_CNT_W-1:0] TIMEOUT_CYC = `IWD_TIMEOUT_CYC
) (
  input wire clk,
  input wire resetn,
  input wire [`IWD_ADDR_W-1:0] io_addr,
  input wire [`IWD_DATA_W-1:0] io_wdata,
  input wire io_wr,
  input wire io_rd,
  output reg [`IWD_DATA_W-1:0] io_rdata,
  input wire timeout_action_strap,
  output reg cpu_reset,
  output reg irq11
);
  // state codes of the arming machine
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_FIRED = 2'h2;
  // pulse length and counter constants, sized to their registers
  localparam [7:0] RST_LEN = `IWD_RST_PULSE_CYC;
  localparam [7:0] RST_ZERO = 8'h00;
  localparam [7:0] RST_ONE = 8'h01;
  localparam [`IWD_CNT_W-1:0] CNT_ZERO = {`IWD_CNT_W{1'b0}};
  localparam [`IWD_CNT_W-1:0] CNT_ONE = {{(`IWD_CNT_W-1){1'b0}}, 1'b1};

  // strap after its synchroniser, and the registered action select
  wire strap_s;
  reg action_q;

  // arming machine
  reg [1:0] state_q;
  reg [1:0] state_d;

  // interval countdown; no prescaler, so the full interval needs 28 bits
  reg [`IWD_CNT_W-1:0] cnt_q;
  reg [`IWD_CNT_W-1:0] cnt_d;

  // expiry actions and the sticky expired flag
  reg [7:0] rst_cnt_q;
  reg [7:0] rst_cnt_d;
  reg cpu_reset_d;
  reg irq11_d;
  reg expired_q;
  reg expired_d;

  // port decode and read path
  wire hit;
  wire wr_one;
  wire wr_zero;
  wire rd_hit;
  wire armed;
  wire timeout;
  wire fire;
  reg [`IWD_DATA_W-1:0] stat_vec;
  wire [`IWD_DATA_W-1:0] rdata_d;
  genvar gi;

  // strap comes from a board jumper, so it is synchronised first
  iwd_sync u_strap (
    .clk(clk),
    .resetn(resetn),
    .din(timeout_action_strap),
    .dout(strap_s)
  );

  // address decode: full 16-bit match only, aliases of the port are ignored
  assign hit = (io_addr == `IWD_PORT_ADDR);
  assign wr_one = hit && io_wr && (io_wdata == `IWD_CMD_REFRESH);
  assign wr_zero = hit && io_wr && (io_wdata == `IWD_CMD_DISABLE);
  assign rd_hit = hit && io_rd;

  // countdown has run out while armed
  assign armed = (state_q == ST_ARMED);
  assign timeout = armed && (cnt_q == CNT_ZERO);
  // a write in the timeout cycle wins, so a late refresh still saves the system
  assign fire = timeout && !wr_one && !wr_zero;

  // arming machine: idle until armed, armed until expiry or disable
  // other written values are ignored, not treated as refresh or disable
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // a first read or a refresh starts the timer
        if (wr_one || rd_hit) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (wr_zero) begin
          state_d = ST_IDLE;
        end else if (fire) begin
          state_d = ST_FIRED;
        end
      end
      ST_FIRED: begin
        // reads are ignored here; only a write leaves the fired state
        if (wr_zero) begin
          state_d = ST_IDLE;
        end else if (wr_one) begin
          state_d = ST_ARMED;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // countdown: reload on arm or refresh, clear on disable, else count down while armed and not yet zero
  always @* begin
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (wr_one || rd_hit) begin
          cnt_d = TIMEOUT_CYC - CNT_ONE;
        end
      end
      ST_ARMED: begin
        if (wr_zero) begin
          cnt_d = CNT_ZERO;
        end else if (wr_one) begin
          cnt_d = TIMEOUT_CYC - CNT_ONE;
        end else if (!timeout) begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_FIRED: begin
        if (wr_zero) begin
          cnt_d = CNT_ZERO;
        end else if (wr_one) begin
          cnt_d = TIMEOUT_CYC - CNT_ONE;
        end
      end
      default: begin
        cnt_d = CNT_ZERO;
      end
    endcase
  end

  // reset pulse counts down in every state, so a rearm during the pulse
  // cannot leave a stale count that would fire again with a later irq
  always @* begin
    rst_cnt_d = rst_cnt_q;
    cpu_reset_d = 1'b0;
    if (rst_cnt_q != RST_ZERO) begin
      rst_cnt_d = rst_cnt_q - RST_ONE;
      cpu_reset_d = 1'b1;
    end
    if (fire && !action_q) begin
      rst_cnt_d = RST_LEN;
    end
  end

  // irq is a level that waits for software: a write of 0 or 1 drops it
  always @* begin
    irq11_d = irq11;
    if (fire && action_q) begin
      irq11_d = 1'b1;
    end else if (wr_zero || wr_one) begin
      irq11_d = 1'b0;
    end
  end

  // expiry sets the flag; a write of 0 in the timeout cycle blocks the expiry and clears it;
  // a refresh leaves it set so software can still see the expiry
  always @* begin
    expired_d = expired_q;
    if (fire) begin
      expired_d = 1'b1;
    end else if (wr_zero) begin
      expired_d = 1'b0;
    end
  end

  // status word: armed, expired and the action that the strap selects
  always @* begin
    stat_vec = {`IWD_DATA_W{1'b0}};
    stat_vec[`IWD_STAT_ARMED_BIT] = armed;
    stat_vec[`IWD_STAT_EXPIRED_BIT] = expired_q;
    stat_vec[`IWD_STAT_ACTION_BIT] = action_q;
  end

  // read data gated per bit, so an off-port or idle cycle returns zero
  generate
    for (gi = 0; gi < `IWD_DATA_W; gi = gi + 1) begin : g_rdata
      assign rdata_d[gi] = rd_hit & stat_vec[gi];
    end
  endgenerate

  // all state cleared by system reset: disarmed, counter zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      rst_cnt_q <= RST_ZERO;
      action_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rst_cnt_q <= rst_cnt_d;
      action_q <= strap_s;
      expired_q <= expired_d;
    end
  end

  // outputs straight from flops; reset holds them low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_reset <= 1'b0;
      irq11 <= 1'b0;
      io_rdata <= {`IWD_DATA_W{1'b0}};
    end else begin
      cpu_reset <= cpu_reset_d;
      irq11 <= irq11_d;
      io_rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// >>> test/iwd_host.sv
// host model: one-cycle strobes on the watchdog port bus
`timescale 1ns/1ps
`default_nettype none
module iwd_host (
  input wire logic clk,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd,
  input wire logic [7:0] io_rdata
);
  // idle bus at time zero
  initial begin
    {io_addr, io_wdata, io_wr, io_rd} = 0;
  end
  // caller spaces refreshes inside the interval
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) #1;
    {io_addr, io_wdata, io_wr, io_rd} = {a, d, w, !w};
    @(posedge clk) #1;
    q = io_rdata;
    // released bus must not keep the old address
    {io_addr, io_wdata, io_wr, io_rd} = {~a, ~d, 2'b00};
  endtask
endmodule
`default_nettype wire

// >>> test/iwd_props.sv
// port and expiry checks of the watchdog
`timescale 1ns/1ps
`default_nettype none
module iwd_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic timeout_action_strap,
  input wire logic cpu_reset,
  input wire logic irq11
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // port decode helpers
  wire hit = io_addr == 16'h0443;
  wire wp = io_wr && hit;
  property p_other; io_rd && !hit |=> io_rdata == 8'h00; endproperty
  a_other: assert property (p_other) else $error("off-port read not zero");
  property p_idle; !io_rd |=> io_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data lingers");
  property p_dis; wp && io_wdata == 8'h00 |=> !irq11; endproperty
  a_dis: assert property (p_dis) else $error("irq after disable");
  property p_ref; wp && io_wdata == 8'h01 |=> !irq11 [*8]; endproperty
  a_ref: assert property (p_ref) else $error("irq soon after refresh");
  property p_one; !(cpu_reset && irq11); endproperty
  a_one: assert property (p_one) else $error("two expiry actions");
  property p_irq; $rose(irq11) |-> timeout_action_strap; endproperty
  a_irq: assert property (p_irq) else $error("irq with reset strap");
  property p_rst; $rose(cpu_reset) |-> !timeout_action_strap; endproperty
  a_rst: assert property (p_rst) else $error("reset with irq strap");
  // 16-cycle reset pulse written as two runs of eight
  property p_pulse; $rose(cpu_reset) |-> cpu_reset [*8] ##1 cpu_reset [*8] ##1 !cpu_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  c_irq: cover property ($rose(irq11));
  c_rst: cover property ($rose(cpu_reset));
  c_rd: cover property (io_rd && hit);
endmodule
bind iwd_top iwd_props u_props (.clk(clk), .resetn(resetn), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .timeout_action_strap(timeout_action_strap),
  .cpu_reset(cpu_reset), .irq11(irq11));
`default_nettype wire

// >>> test/iwd_top_tb.sv
// self-checking bench of the watchdog
`timescale 1ns/1ps
`default_nettype none
module iwd_top_tb;
  logic clk, resetn, strap, wr, rd, rst_o, irq;
  logic [15:0] ad;
  logic [7:0] wd, rdat, q;
  logic [1:0] seen;
  int failures, tests_run;
  iwd_top #(.TIMEOUT_CYC(28'h32)) u_dut (.clk(clk), .resetn(resetn), .io_addr(ad), .io_wdata(wd), .io_wr(wr),
    .io_rd(rd), .io_rdata(rdat), .timeout_action_strap(strap), .cpu_reset(rst_o), .irq11(irq));
  iwd_host u_host (.clk(clk), .io_addr(ad), .io_wdata(wd), .io_wr(wr), .io_rd(rd), .io_rdata(rdat));
  task test_done;
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  // gather expiry outputs, since a reset pulse is short
  task idle(input int n);
    seen = 0;
    repeat (n) @(posedge clk) #1 seen = seen | {rst_o, irq};
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // watchdog against a hung run
  initial begin
    #20000;
    failures++;
    test_done;
  end
  initial begin
    // strap starts on the irq action
    resetn = 0;
    strap = 1;
    failures = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    #1 resetn = 1;
    u_host.acc(0, 16'h0443, 8'h00, q);
    chk("arm0", 8'h00, q & 8'h01);
    u_host.acc(0, 16'h0443, 8'h00, q);
    chk("arm1", 8'h01, q & 8'h01);
    idle(40);
    u_host.acc(1, 16'h0443, 8'h01, q);
    idle(45);
    chk("early", 8'h00, seen);
    idle(20);
    chk("irq", 8'h01, seen);
    u_host.acc(0, 16'h0443, 8'h00, q);
    chk("stat", 8'h06, q);
    u_host.acc(1, 16'h0443, 8'h00, q);
    idle(80);
    chk("off", 8'h00, seen);
    u_host.acc(0, 16'h0444, 8'h00, q);
    chk("other", 8'h00, q);
    strap = 0;
    u_host.acc(1, 16'h0443, 8'h01, q);
    idle(70);
    chk("rst", 8'h02, seen);
    // mid-run reset while armed: timer must come back disarmed
    u_host.acc(1, 16'h0443, 8'h01, q);
    idle(10);
    resetn = 0;
    repeat (4) @(posedge clk);
    #1 resetn = 1;
    idle(60);
    chk("rst_clr", 8'h00, seen);
    u_host.acc(0, 16'h0443, 8'h00, q);
    chk("stat_clr", 8'h00, q);
    // disable straight from the armed state
    u_host.acc(1, 16'h0443, 8'h00, q);
    idle(60);
    chk("dis", 8'h00, seen);
    test_done;
  end
endmodule
`default_nettype wire
